// ### pkg/can_ctl_pkg.sv
// constants and register map of the can control and bit-timing slice
// Functional notes
// - control one writable only in initialization mode
// - module enable written once, unless special mode
// - module enable bit 7 enables controller
// - bit 6 picks oscillator or bus clock
// - loopback feeds transmit stream into receiver
// - listen-only: receive, no acknowledge, no errors
// - listen-only freezes both error counters
// - listen-only transmits no messages
// - bit 3 picks automatic or requested recovery
// - bit 2 picks any-dominant or filtered wake
// - sleep acknowledge set on sleep entry
// - sleep acknowledge cleared by request clear, wake
// - init acknowledge marks initialization mode
// - configuration writes only during initialization mode
// - timing zero readable always, written in init
// - jump width is field plus one quanta
// - prescaler divides protocol clock by field+1
// - init request aborts traffic, drops synchronization
// - sleep honoured only while bus idle
package can_ctl_pkg;
  // register offsets
  localparam logic [1:0] OFS_CONTROL_ZERO = 2'h0;
  localparam logic [1:0] OFS_CONTROL_ONE  = 2'h1;
  localparam logic [1:0] OFS_TIMING_ZERO  = 2'h2;
  // control zero field positions
  localparam int BIT_INIT_REQUEST  = 0;
  localparam int BIT_SLEEP_REQUEST = 1;
  localparam int BIT_WAKE_ENABLE   = 2;
  // control one field positions
  localparam int BIT_MODULE_ENABLE = 7;
  localparam int BIT_CLOCK_SELECT  = 6;
  localparam int BIT_LOOPBACK      = 5;
  localparam int BIT_LISTEN_ONLY   = 4;
  localparam int BIT_BUSOFF_SELECT = 3;
  localparam int BIT_WAKE_FILTER   = 2;
  localparam int BIT_SLEEP_ACK     = 1;
  localparam int BIT_INIT_ACK      = 0;
  // timing zero fields
  localparam int JUMP_MSB = 7;
  localparam int JUMP_LSB = 6;
  localparam int PRESC_MSB = 5;
  // reset values
  localparam logic [7:0] RST_CONTROL_ZERO = 8'h01;
  localparam logic [7:0] RST_CONTROL_ONE  = 8'h01;
  localparam logic [7:0] RST_TIMING_ZERO  = 8'h00;
  // timing
  localparam int CLK_MHZ        = 25;
  localparam int WAKE_FILTER_NS = 2000;
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
endpackage

// ### rtl/can_control_and_bit_timing.sv
// control register one, bit-timing register zero and mode handshakes
`timescale 1ns/1ps
module can_control_and_bit_timing #(
  parameter int WAKE_CYC = can_ctl_pkg::WAKE_FILTER_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // system
  input  wire logic       special_mode,
  input  wire logic       osc_tick,
  // protocol core side
  input  wire logic       core_tx_bit,
  input  wire logic       core_bus_idle,
  output logic            core_rx_bit,
  output logic            core_abort,
  output logic            core_enable,
  output logic            core_sleep,
  output logic            tq_tick,
  output logic [2:0]      jump_width_tq,
  output logic            ack_enable,
  output logic            tx_enable,
  output logic            err_count_freeze,
  output logic            busoff_recovery_select,
  // pins
  input  wire logic       can_rx_pin,
  output logic            can_tx_pin
);
  initial begin
    if (WAKE_CYC < 1 || WAKE_CYC > 65535) begin
      $error("wake filter count out of range");
    end
  end

  logic [7:0]  control_zero_r;
  logic [7:0]  control_one_r;
  logic [7:0]  timing_zero_r;
  logic        enable_written_r;
  logic [5:0]  presc_cnt_r;
  logic [15:0] wake_cnt_r;
  logic        rx_s1_r;
  logic        rx_s2_r;

  // decode
  wire init_mode   = control_zero_r[can_ctl_pkg::BIT_INIT_REQUEST] &
                     control_one_r[can_ctl_pkg::BIT_INIT_ACK];
  wire sleep_mode  = control_zero_r[can_ctl_pkg::BIT_SLEEP_REQUEST] &
                     control_one_r[can_ctl_pkg::BIT_SLEEP_ACK];
  wire wr_ctl0     = reg_wr & (reg_addr == can_ctl_pkg::OFS_CONTROL_ZERO);
  wire wr_ctl1     = reg_wr & (reg_addr == can_ctl_pkg::OFS_CONTROL_ONE) & init_mode;
  wire wr_btr0     = reg_wr & (reg_addr == can_ctl_pkg::OFS_TIMING_ZERO) & init_mode;
  wire enable_ok   = special_mode | ~enable_written_r;
  wire module_en   = control_one_r[can_ctl_pkg::BIT_MODULE_ENABLE];
  wire listen_only = control_one_r[can_ctl_pkg::BIT_LISTEN_ONLY];
  wire loopback    = control_one_r[can_ctl_pkg::BIT_LOOPBACK];
  wire wake_filter = control_one_r[can_ctl_pkg::BIT_WAKE_FILTER];
  wire wake_on     = control_zero_r[can_ctl_pkg::BIT_WAKE_ENABLE];
  wire rx_dominant = ~rx_s2_r;

  // wake: any dominant level, or dominant held for the filter length
  wire wake_event  = sleep_mode & wake_on & rx_dominant &
                     (~wake_filter | (wake_cnt_r >= 16'(WAKE_CYC - 1)));

  // request bits: cpu cannot drop a request before its acknowledge
  wire init_req_w  = reg_wdata[can_ctl_pkg::BIT_INIT_REQUEST];
  wire slp_req_w   = reg_wdata[can_ctl_pkg::BIT_SLEEP_REQUEST];
  wire init_req_nxt = wr_ctl0 ? (init_req_w | (control_zero_r[0] & ~init_mode))
                              : control_zero_r[0];
  wire slp_req_set = wr_ctl0 ? (slp_req_w | (control_zero_r[1] & ~sleep_mode))
                             : control_zero_r[1];
  wire slp_req_nxt = slp_req_set & ~wake_event;
  wire wake_en_nxt = wr_ctl0 ? reg_wdata[can_ctl_pkg::BIT_WAKE_ENABLE] : wake_on;

  // init acknowledge follows its request one cycle later; sleep acknowledge also waits for an idle bus and no init request
  wire init_ack_nxt = control_zero_r[0];
  wire slp_ack_nxt  = control_zero_r[1] & ~wake_event &
                      (control_one_r[1] | (core_bus_idle & ~control_zero_r[0]));

  // protocol clock: oscillator tick or every bus clock
  wire prot_tick = control_one_r[can_ctl_pkg::BIT_CLOCK_SELECT] | osc_tick;
  wire presc_run = module_en & ~control_zero_r[0];
  wire presc_end = presc_cnt_r == timing_zero_r[can_ctl_pkg::PRESC_MSB:0];

  // read mux
  wire [7:0] rd_mux = (reg_addr == can_ctl_pkg::OFS_CONTROL_ZERO) ?
                        {5'h00, control_zero_r[2:0]} :
                      (reg_addr == can_ctl_pkg::OFS_CONTROL_ONE) ? control_one_r :
                      (reg_addr == can_ctl_pkg::OFS_TIMING_ZERO) ? timing_zero_r : 8'h00;

  // pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= can_rx_pin;
      rx_s2_r <= rx_s1_r;
    end
  end

  // control zero: requests and wake enable
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      control_zero_r <= can_ctl_pkg::RST_CONTROL_ZERO;
    end else begin
      control_zero_r <= {5'h00, wake_en_nxt, slp_req_nxt, init_req_nxt};
    end
  end

  // control one: configuration only in init mode, acks always tracked
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      control_one_r    <= can_ctl_pkg::RST_CONTROL_ONE;
      enable_written_r <= 1'b0;
    end else begin
      if (wr_ctl1) begin
        control_one_r[6:2] <= reg_wdata[6:2];
        if (enable_ok) begin
          control_one_r[7] <= reg_wdata[7];
        end
        enable_written_r <= 1'b1;
      end
      control_one_r[1] <= slp_ack_nxt;
      control_one_r[0] <= init_ack_nxt;
    end
  end

  // timing zero: jump width and prescaler
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timing_zero_r <= can_ctl_pkg::RST_TIMING_ZERO;
    end else if (wr_btr0) begin
      timing_zero_r <= reg_wdata;
    end
  end

  // quantum divider, held in reset while initializing so it restarts aligned
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !presc_run) begin
      presc_cnt_r <= 6'h00;
      tq_tick     <= 1'b0;
    end else begin
      tq_tick <= prot_tick & presc_end;
      if (prot_tick) begin
        presc_cnt_r <= presc_end ? 6'h00 : presc_cnt_r + 6'h01;
      end
    end
  end

  // wake filter counter, saturating; counts only dominant time in sleep
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !(sleep_mode && rx_dominant)) begin
      wake_cnt_r <= 16'h0000;
    end else if (wake_cnt_r != 16'hffff) begin
      wake_cnt_r <= wake_cnt_r + 16'h0001;
    end
  end

  // register read port, data valid the cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // core controls; tx forced recessive on init request to protect the bus
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      core_rx_bit            <= 1'b1;
      core_abort             <= 1'b1;
      core_enable            <= 1'b0;
      core_sleep             <= 1'b0;
      jump_width_tq          <= 3'h1;
      ack_enable             <= 1'b0;
      tx_enable              <= 1'b0;
      err_count_freeze       <= 1'b0;
      busoff_recovery_select <= 1'b0;
      can_tx_pin             <= 1'b1;
    end else begin
      core_rx_bit   <= loopback ? core_tx_bit : rx_s2_r;
      core_abort    <= init_req_nxt;
      core_enable   <= module_en;
      core_sleep    <= slp_ack_nxt & slp_req_nxt;
      jump_width_tq <= {1'b0, timing_zero_r[can_ctl_pkg::JUMP_MSB:can_ctl_pkg::JUMP_LSB]}
                       + 3'h1;
      ack_enable    <= ~listen_only;
      tx_enable     <= ~listen_only & module_en;
      err_count_freeze <= listen_only;
      busoff_recovery_select <= control_one_r[can_ctl_pkg::BIT_BUSOFF_SELECT];
      can_tx_pin    <= (init_req_nxt | listen_only | loopback | ~module_en) ? 1'b1
                       : core_tx_bit;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_CTL1_LOCKED: assert property (reg_wr && reg_addr == can_ctl_pkg::OFS_CONTROL_ONE
    && !init_mode |=> $stable(control_one_r[7:2]))
    else $error("control one changed outside init mode");
  AST_ENABLE_ONCE: assert property (enable_written_r && !special_mode
    |=> $stable(control_one_r[7]))
    else $error("module enable rewritten in normal mode");
  AST_ENABLE_OUT: assert property (##1 core_enable == $past(module_en))
    else $error("core enable does not follow bit 7");
  AST_LOOPBACK: assert property (loopback |=> core_rx_bit == $past(core_tx_bit))
    else $error("loopback not fed back");
  AST_LISTEN: assert property (listen_only |=> !ack_enable && !tx_enable
    && err_count_freeze && can_tx_pin)
    else $error("listen-only still active on bus");
  AST_SLEEP_IDLE: assert property ($rose(control_one_r[1]) |-> $past(core_bus_idle))
    else $error("sleep entered while bus busy");
  AST_SLEEP_CLR: assert property (!control_zero_r[1] |=> !control_one_r[1])
    else $error("sleep acknowledge kept without request");
  AST_INIT_ACK: assert property ($rose(control_zero_r[0]) |=> control_one_r[0])
    else $error("init acknowledge late");
  AST_BTR_LOCK: assert property (!init_mode |=> $stable(timing_zero_r))
    else $error("timing zero changed outside init mode");
  AST_JUMP: assert property (##1 jump_width_tq == $past(timing_zero_r[7:6]) + 3'h1)
    else $error("jump width wrong");
  AST_DIV1: assert property (presc_run && prot_tick && timing_zero_r[5:0] == 6'h00
    && $past(presc_run) |=> tq_tick)
    else $error("prescaler one misses tick");
  AST_ABORT: assert property (init_req_nxt |=> core_abort && can_tx_pin)
    else $error("init request did not abort");
  AST_RESET_BTR: assert property ($rose(rst_n) |-> timing_zero_r == 8'h00)
    else $error("timing zero reset value wrong");

  // read port returns zero when no read strobe came, so stale data never leaks
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero without strobe");

  // control one readable at any time, captured the cycle after the strobe
  AST_RDATA_CTL1: assert property (reg_rd && reg_addr == can_ctl_pkg::OFS_CONTROL_ONE
    |=> reg_rdata == $past(control_one_r))
    else $error("control one read back wrong");

  // timing zero readable at any time
  AST_RDATA_BTR: assert property (reg_rd && reg_addr == can_ctl_pkg::OFS_TIMING_ZERO
    |=> reg_rdata == $past(timing_zero_r))
    else $error("timing zero read back wrong");

  // an accepted timing write lands whole
  AST_BTR_WRITE: assert property (wr_btr0 |=> timing_zero_r == $past(reg_wdata))
    else $error("timing zero write lost");

  // an accepted control write lands in the configuration bits
  AST_CTL1_WRITE: assert property (wr_ctl1
    |=> control_one_r[6:2] == $past(reg_wdata[6:2]))
    else $error("control one write lost");

  // special operation may rewrite the enable any number of times
  AST_ENABLE_SPECIAL: assert property (wr_ctl1 && special_mode
    |=> control_one_r[7] == $past(reg_wdata[7]))
    else $error("module enable not writable in special mode");

  // divider is parked while disabled or initializing
  AST_TQ_IDLE: assert property (!presc_run |=> !tq_tick)
    else $error("quantum tick while divider parked");

  // with a prescaler above one, ticks never come back to back
  AST_TQ_SPACING: assert property (tq_tick && timing_zero_r[5:0] != 6'h00
    |=> !tq_tick)
    else $error("quantum ticks too close");

  // sleep output mirrors the request and acknowledge pair
  AST_SLEEP_OUT: assert property (core_sleep == sleep_mode)
    else $error("sleep output differs from sleep mode");

  // abort level follows the init request bit
  AST_ABORT_LEVEL: assert property (core_abort == control_zero_r[0])
    else $error("abort differs from init request");

  // a disabled controller keeps the bus recessive
  AST_TX_RECESSIVE: assert property (!core_enable |-> can_tx_pin)
    else $error("transmit pin driven while disabled");

  // wake clears both the request and its acknowledge
  AST_WAKE_CLR: assert property (wake_event
    |=> !control_one_r[1] && !control_zero_r[1])
    else $error("wake did not clear sleep");

  // without wake enable, sleep holds until the cpu clears it
  AST_WAKE_OFF: assert property (sleep_mode && !wake_on && !wr_ctl0
    |=> control_zero_r[1] && control_one_r[1])
    else $error("sleep left without wake enable");

  // unfiltered wake reacts to any dominant level
  AST_WAKE_ANY: assert property (sleep_mode && wake_on && !wake_filter && rx_dominant
    |=> !control_one_r[1])
    else $error("unfiltered wake missed");

  // a pending init request keeps sleep from being entered
  AST_SLEEP_NO_INIT: assert property (control_zero_r[0] && !control_one_r[1]
    |=> !control_one_r[1])
    else $error("sleep entered during init request");

  // init acknowledge drops once the request is gone
  AST_ACK_ZERO: assert property (!control_zero_r[0] |=> !control_one_r[0])
    else $error("init acknowledge kept without request");

  // cpu cannot drop the init request before it is acknowledged
  AST_REQ_HOLD: assert property (wr_ctl0 && control_zero_r[0] && !init_mode
    |=> control_zero_r[0])
    else $error("init request dropped before acknowledge");

  // receive path follows the synchronised pin outside loopback
  AST_RX_PASS: assert property (!loopback |=> core_rx_bit == $past(rx_s2_r))
    else $error("receive bit not from pin");

  // recovery select is passed to the core one cycle later
  AST_BUSOFF: assert property (##1 busoff_recovery_select == $past(control_one_r[3]))
    else $error("recovery select not forwarded");

  // acknowledges sent again once listen-only is off
  AST_ACK_OUT: assert property (!listen_only |=> ack_enable)
    else $error("acknowledge disabled in normal mode");

  // counters run again once listen-only is off
  AST_FREEZE_OFF: assert property (!listen_only |=> !err_count_freeze)
    else $error("error counters frozen in normal mode");

  // transmission allowed when enabled and not listening
  AST_TX_ON: assert property (!listen_only && module_en |=> tx_enable)
    else $error("transmit disabled in normal mode");

  // jump width stays inside one to four quanta
  AST_JUMP_RANGE: assert property (jump_width_tq >= 3'h1 && jump_width_tq <= 3'h4)
    else $error("jump width out of range");

  COV_INIT: cover property (control_zero_r[0] ##1 init_mode ##[1:20] wr_btr0);
  COV_SLEEP: cover property (slp_ack_nxt ##1 sleep_mode);
  COV_WAKE: cover property (sleep_mode && wake_filter ##[1:200] wake_event);
  COV_TQ: cover property (tq_tick ##[2:200] tq_tick);
endmodule

// ### verif/can_bus_node.sv
// far-side bus node model: wired-and bus with recessive pull-up
`timescale 1ns/1ps
module can_bus_node (
  // device pins
  input  wire logic tx_pin,
  output logic      rx_pin,
  // bench control of this node
  input  wire logic dominant
);
  // dominant wins; a released bus returns to the pull-up level
  assign rx_pin = tx_pin & ~dominant;
endmodule

// ### verif/can_control_and_bit_timing_tb.sv
// self-checking bench for the control and bit-timing slice
`timescale 1ns/1ps
module can_control_and_bit_timing_tb;
  localparam logic [1:0] A0 = can_ctl_pkg::OFS_CONTROL_ZERO;
  localparam logic [1:0] A1 = can_ctl_pkg::OFS_CONTROL_ONE;
  localparam logic [1:0] A2 = can_ctl_pkg::OFS_TIMING_ZERO;
  logic       clk_sys, rst_n, reg_wr, reg_rd, special_mode;
  logic       core_tx_bit, core_bus_idle, dom, rx_pin;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, n;
  logic       core_rx_bit, core_abort, core_enable, core_sleep, tq_tick;
  logic [2:0] jump_width_tq;
  logic       ack_enable, tx_enable, err_count_freeze, bo_sel, can_tx_pin;
  logic       osc_tick = 1'b0;
  int         tmo = 0;
  int         n_mismatch = 0;
  int         n_compared = 0;

  // short filter so the wake path finishes quickly
  can_control_and_bit_timing #(.WAKE_CYC(4)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .special_mode(special_mode),
    .osc_tick(osc_tick), .core_tx_bit(core_tx_bit),
    .core_bus_idle(core_bus_idle), .core_rx_bit(core_rx_bit),
    .core_abort(core_abort), .core_enable(core_enable),
    .core_sleep(core_sleep), .tq_tick(tq_tick),
    .jump_width_tq(jump_width_tq), .ack_enable(ack_enable),
    .tx_enable(tx_enable), .err_count_freeze(err_count_freeze),
    .busoff_recovery_select(bo_sel), .can_rx_pin(rx_pin),
    .can_tx_pin(can_tx_pin));

  can_bus_node node (.tx_pin(can_tx_pin), .rx_pin(rx_pin), .dominant(dom));

  always #20 clk_sys = ~clk_sys;

  // cycle ceiling; osc ticks every other cycle, a half-rate protocol clock
  always @(posedge clk_sys) begin
    tmo <= tmo + 1;
    osc_tick <= ~osc_tick;
    if (tmo == 2000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask

  // count quantum ticks over 40 cycles
  task automatic ticks(input logic [7:0] e);
    n = 8'h00;
    repeat (40) begin
      @(posedge clk_sys);
      #1 n = n + {7'h00, tq_tick};
    end
    chk("tq_tick", e, n);
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial begin
    clk_sys = 0; rst_n = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0;
    reg_rd = 0; special_mode = 0; core_tx_bit = 1; core_bus_idle = 1;
    dom = 0;
    cyc(8);
    rst_n <= 1'b1;
    rd(A1, 8'h01);
    rd(A2, 8'h00);
    rd(2'h3, 8'h00);
    chk("abort", 8'h01, core_abort);
    wr(A2, 8'hc3);
    rd(A2, 8'hc3);
    chk("sjw", 8'h04, jump_width_tq);
    wr(A1, 8'hdb);
    rd(A1, 8'hd9);
    chk("freeze", 8'h01, err_count_freeze);
    chk("tx_en", 8'h00, tx_enable);
    chk("ack_en", 8'h00, ack_enable);
    chk("busoff", 8'h01, bo_sel);
    wr(A1, 8'h40);
    rd(A1, 8'hc1);
    wr(A0, 8'h00);
    cyc(2);
    rd(A1, 8'hc0);
    chk("abort", 8'h00, core_abort);
    chk("enable", 8'h01, core_enable);
    ticks(8'd10);
    wr(A2, 8'h00);
    rd(A2, 8'hc3);
    wr(A1, 8'h00);
    rd(A1, 8'hc0);
    // loopback on oscillator clock
    wr(A0, 8'h01);
    cyc(2);
    chk("abort", 8'h01, core_abort);
    wr(A1, 8'h20);
    rd(A1, 8'ha1);
    wr(A0, 8'h00);
    cyc(2);
    core_tx_bit <= 1'b0;
    cyc(3);
    chk("loop_rx", 8'h00, core_rx_bit);
    chk("tx_pin", 8'h01, can_tx_pin);
    core_tx_bit <= 1'b1;
    ticks(8'd5);
    // special mode may clear the enable; then sleep and wake
    wr(A0, 8'h01);
    cyc(2);
    special_mode <= 1'b1;
    wr(A1, 8'h00);
    rd(A1, 8'h01);
    chk("enable", 8'h00, core_enable);
    wr(A1, 8'hc4);
    rd(A1, 8'hc5);
    wr(A0, 8'h00);
    cyc(2);
    core_bus_idle <= 1'b0;
    wr(A0, 8'h02);
    cyc(3);
    rd(A1, 8'hc4);
    core_bus_idle <= 1'b1;
    cyc(2);
    chk("sleep", 8'h01, core_sleep);
    rd(A1, 8'hc6);
    wr(A0, 8'h00);
    cyc(2);
    chk("sleep", 8'h00, core_sleep);
    wr(A0, 8'h06);
    cyc(3);
    chk("sleep", 8'h01, core_sleep);
    dom <= 1'b1;
    cyc(2);
    chk("sleep", 8'h01, core_sleep);
    cyc(8);
    chk("sleep", 8'h00, core_sleep);
    dom <= 1'b0;
    end_of_test;
  end
endmodule
